/* File: logic/acc_conversion_control.sv */
// converter control: registers, triggers, sequencing and result capture
`timescale 1ns/1ns
module acc_conversion_control
  import acc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  output logic [7:0]       sfr_rdata,
  input  wire logic        timer_overflow,
  input  wire logic        external_convert_pin_b,
  input  wire logic        cal_wr,
  input  wire logic [7:0]  cal_offset_in,
  input  wire logic [7:0]  cal_gain_in,
  input  wire logic [11:0] sar_code,
  output logic             converter_power_mode,
  output logic             ext_ref_select,
  output logic [3:0]       mux_channel,
  output logic             track_hold,
  output logic             sar_strobe,
  output logic [7:0]       cal_offset,
  output logic [7:0]       cal_gain,
  output logic [23:0]      dma_addr,
  output logic [15:0]      dma_data,
  output logic             dma_valid,
  input  wire logic        dma_ready
);
  logic [7:0]  cfg_q;
  logic [7:0]  ctl2_q;
  logic [7:0]  res_lo_q;
  logic [7:0]  res_hi_q;
  logic [7:0]  ofs_q;
  logic [7:0]  gain_q;
  logic        pin_q;
  logic        pin_fall;
  logic [5:0]  div_ratio;
  logic [5:0]  div_cnt_q;
  logic        adc_tick;
  logic [2:0]  acq_clks;
  logic [4:0]  step_q;
  acc_state_t  state_q;
  logic        trigger;
  logic        finish;
  logic        dma_mode;
  logic [3:0]  conv_ch_q;
  logic [3:0]  dma_ch_q;
  logic [23:0] dma_addr_q;
  acc_sample_t sample;
  logic        fifo_ready;
  logic        wr_cfg;
  logic        wr_ctl2;

  assign wr_cfg   = sfr_wr && (sfr_addr == ACC_CFG_ADDR);
  assign wr_ctl2  = sfr_wr && (sfr_addr == ACC_CTL2_ADDR);
  assign dma_mode = ctl2_q[ACC_DMA_BIT];

  assign converter_power_mode = cfg_q[ACC_POWER_BIT];
  assign ext_ref_select = cfg_q[ACC_EXTREF_BIT];

  // configuration register, cleared by reset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= ACC_CFG_RESET;
    end else if (wr_cfg) begin
      cfg_q <= sfr_wdata;
    end
  end

  always_comb begin
    unique case ({cfg_q[ACC_CKHI_BIT], cfg_q[ACC_CKLO_BIT]})
      2'b00: div_ratio = ACC_DIV_00;
      2'b01: div_ratio = ACC_DIV_01;
      2'b10: div_ratio = ACC_DIV_10;
      2'b11: div_ratio = ACC_DIV_11;
    endcase
  end

  // converter clock enable pulse; held in idle so that acquisition and
  // conversion always span whole converter clocks
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_q <= '0;
    end else if (!converter_power_mode || state_q == ACC_IDLE
                 || div_cnt_q >= div_ratio - 6'h01) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + 6'h01;
    end
  end
  assign adc_tick = converter_power_mode && (div_cnt_q == div_ratio - 6'h01);

  assign acq_clks = {1'b0, cfg_q[ACC_AQHI_BIT], cfg_q[ACC_AQLO_BIT]} + 3'h1;

  // falling edge of the convert pin
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= external_convert_pin_b;
    end
  end
  assign pin_fall = pin_q && !external_convert_pin_b;

  // start sources: software, timer, pin, continuous, dma
  // single or continuous by software, single by timer or pin
  always_comb begin
    trigger = ctl2_q[ACC_SINGLE_BIT]
           || ctl2_q[ACC_CONT_BIT]
           || dma_mode
           || (cfg_q[ACC_TIMER_BIT] && timer_overflow)
           || (cfg_q[ACC_PIN_BIT] && pin_fall);
  end

  assign finish = (state_q == ACC_CONVERT) && adc_tick
               && (step_q == ACC_CONV_CLKS - 5'h01);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ACC_IDLE;
      step_q  <= '0;
    end else if (!converter_power_mode) begin
      state_q <= ACC_IDLE;
      step_q  <= '0;
    end else begin
      unique case (state_q)
        ACC_IDLE: begin
          step_q <= '0;
          if (trigger && fifo_ready) begin
            state_q <= ACC_ACQUIRE;
          end
        end
        ACC_ACQUIRE: begin
          if (adc_tick) begin
            if (step_q == {2'b00, acq_clks} - 5'h01) begin
              state_q <= ACC_CONVERT;
              step_q  <= '0;
            end else begin
              step_q <= step_q + 5'h01;
            end
          end
        end
        ACC_CONVERT: begin
          if (adc_tick) begin
            if (finish) begin
              state_q <= ACC_IDLE;
              step_q  <= '0;
            end else begin
              step_q <= step_q + 5'h01;
            end
          end
        end
        default: begin
          state_q <= ACC_IDLE;
          step_q  <= '0;
        end
      endcase
    end
  end

  // channel latched at start; dma cycles channels
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_ch_q <= '0;
      dma_ch_q  <= '0;
    end else if (state_q == ACC_IDLE && trigger && fifo_ready
                 && converter_power_mode) begin
      if (dma_mode) begin
        conv_ch_q <= dma_ch_q;
        dma_ch_q  <= (dma_ch_q == ACC_TEMP_CH) ? 4'h0 : dma_ch_q + 4'h1;
      end else begin
        conv_ch_q <= ctl2_q[3:0];
      end
    end
  end
  assign mux_channel = conv_ch_q;
  assign track_hold  = (state_q == ACC_ACQUIRE);
  assign sar_strobe  = finish;

  // control register 2 with done flag, single start self-clears
  // done flag set wins over software clear
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl2_q <= ACC_CTL2_RESET;
    end else begin
      if (wr_ctl2) begin
        ctl2_q <= sfr_wdata;
      end else if (state_q == ACC_IDLE && trigger && fifo_ready
                   && converter_power_mode) begin
        ctl2_q[ACC_SINGLE_BIT] <= 1'b0;
      end
      if (finish) begin
        ctl2_q[ACC_DONE_BIT] <= 1'b1;
      end
    end
  end

  // straight binary code, clipped to full scale
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      res_lo_q <= '0;
      res_hi_q <= '0;
    end else if (finish) begin
      res_lo_q <= sar_code[7:0];
      res_hi_q <= {conv_ch_q, sar_code[11:8] & ACC_FULL_CODES[11:8]};
    end
  end

  // factory load at reset; hardware calibration update
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ofs_q  <= ACC_OFS_FACTORY;
      gain_q <= ACC_GAIN_FACTORY;
    end else if (cal_wr) begin
      ofs_q  <= cal_offset_in;
      gain_q <= cal_gain_in;
    end else begin
      if (sfr_wr && sfr_addr == ACC_OFS_ADDR) begin
        ofs_q <= sfr_wdata;
      end
      if (sfr_wr && sfr_addr == ACC_GAIN_ADDR) begin
        gain_q <= sfr_wdata;
      end
    end
  end
  assign cal_offset = ofs_q;
  assign cal_gain   = gain_q;

  // register read mux; unmapped reads return zero
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata <= '0;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        ACC_CFG_ADDR:    sfr_rdata <= cfg_q;
        ACC_CTL2_ADDR:   sfr_rdata <= ctl2_q;
        ACC_RES_LO_ADDR: sfr_rdata <= res_lo_q;
        ACC_RES_HI_ADDR: sfr_rdata <= res_hi_q;
        ACC_OFS_ADDR:    sfr_rdata <= ofs_q;
        ACC_GAIN_ADDR:   sfr_rdata <= gain_q;
        default:         sfr_rdata <= 8'h00;
      endcase
    end
  end

  // dma samples buffered toward external memory
  assign sample.channel = conv_ch_q;
  assign sample.code    = sar_code;

  acc_fifo #(
    .WIDTH (ACC_FIFO_W),
    .DEPTH (ACC_FIFO_D)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .in_data   (sample),
    .in_valid  (finish && dma_mode),
    .in_ready  (fifo_ready),
    .out_data  (dma_data),
    .out_valid (dma_valid),
    .out_ready (dma_ready)
  );

  // dma address walks the 16 MByte space, two bytes per sample
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dma_addr_q <= '0;
    end else if (!dma_mode) begin
      dma_addr_q <= '0;
    end else if (dma_valid && dma_ready) begin
      dma_addr_q <= (dma_addr_q >= ACC_DMA_TOP - 24'h1) ? '0
                                                       : dma_addr_q + 24'h2;
    end
  end
  assign dma_addr = dma_addr_q;
endmodule : acc_conversion_control

/* File: logic/acc_pkg.sv */
// package with register map, field positions and timing constants
package acc_pkg;
  localparam logic [7:0] ACC_CFG_ADDR    = 8'hef; // converter_config
  localparam logic [7:0] ACC_CTL2_ADDR   = 8'hd8; // mode and channel
  localparam logic [7:0] ACC_RES_LO_ADDR = 8'hd9; // result low byte
  localparam logic [7:0] ACC_RES_HI_ADDR = 8'hda; // result_high
  localparam logic [7:0] ACC_OFS_ADDR    = 8'hf1; // offset calibration
  localparam logic [7:0] ACC_GAIN_ADDR   = 8'hf3; // gain calibration
  localparam logic [7:0] ACC_CFG_RESET   = 8'h00;
  localparam logic [7:0] ACC_CTL2_RESET  = 8'h00;
  localparam int ACC_POWER_BIT   = 7;
  localparam int ACC_EXTREF_BIT  = 6;
  localparam int ACC_CKHI_BIT    = 5;
  localparam int ACC_CKLO_BIT    = 4;
  localparam int ACC_AQHI_BIT    = 3;
  localparam int ACC_AQLO_BIT    = 2;
  localparam int ACC_TIMER_BIT   = 1;
  localparam int ACC_PIN_BIT     = 0;
  localparam int ACC_DONE_BIT    = 7;
  localparam int ACC_DMA_BIT     = 6;
  localparam int ACC_CONT_BIT    = 5;
  localparam int ACC_SINGLE_BIT  = 4;
  localparam int ACC_CHANNELS    = 9;     // eight inputs plus temperature
  localparam logic [3:0] ACC_TEMP_CH = 4'h8;
  localparam logic [11:0] ACC_FULL_CODES = 12'hfff; // 4096 codes
  localparam logic [4:0] ACC_CONV_CLKS = 5'h11;     // 17 converter clocks
  localparam logic [5:0] ACC_DIV_00 = 6'h08;
  localparam logic [5:0] ACC_DIV_01 = 6'h04;
  localparam logic [5:0] ACC_DIV_10 = 6'h10;
  localparam logic [5:0] ACC_DIV_11 = 6'h20;
  localparam logic [7:0] ACC_OFS_FACTORY  = 8'h00; // arbitrary default
  localparam logic [7:0] ACC_GAIN_FACTORY = 8'h80; // arbitrary default
  localparam int ACC_FIFO_W = 16;
  localparam int ACC_FIFO_D = 4;
  localparam logic [23:0] ACC_DMA_TOP = 24'hffffff; // 16 MByte space
  typedef struct packed {
    logic [3:0]  channel;
    logic [11:0] code;
  } acc_sample_t;
  typedef enum logic [1:0] {
    ACC_IDLE    = 2'b00,
    ACC_ACQUIRE = 2'b01,
    ACC_CONVERT = 2'b10
  } acc_state_t;
endpackage : acc_pkg

/* File: logic/acc_fifo.sv */
// small sample fifo with valid/ready on both sides
`timescale 1ns/1ns
module acc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;
  // handshake terms
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q];
  // storage write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  // pointers and fill count
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : acc_fifo

/* File: verif/acc_far_model.sv */
// far-side model: analog core result, convert pin and sample sink
`timescale 1ns/1ns
module acc_far_model (
  input  wire logic        ref_clk,
  input  wire logic [3:0]  mux_channel,
  input  wire logic        pin_go,
  input  wire logic        stall,
  output logic [11:0]      sar_code,
  output logic             external_convert_pin_b,
  output logic             dma_ready
);
  int low_cnt = 0;
  // result pattern carries the channel so every capture is traceable
  assign sar_code = {8'ha5, mux_channel};
  assign dma_ready = !stall;
  // low pulse, launched after the edge that sees pin_go
  always @(posedge ref_clk) begin
    if (pin_go) low_cnt <= 13; // wider than 100 ns
    else if (low_cnt != 0) low_cnt <= low_cnt - 1;
  end
  assign external_convert_pin_b = (low_cnt == 0);
endmodule : acc_far_model

/* File: verif/acc_conversion_control_sva.sv */
// assertion checker bound to the converter control block
`timescale 1ns/1ns
module acc_checker
  import acc_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic [7:0]  sfr_addr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        cal_wr,
  input wire logic [7:0]  cal_offset_in,
  input wire logic [7:0]  cal_gain_in,
  input wire logic        converter_power_mode,
  input wire logic        ext_ref_select,
  input wire logic [3:0]  mux_channel,
  input wire logic        track_hold,
  input wire logic        sar_strobe,
  input wire logic [7:0]  cal_offset,
  input wire logic [7:0]  cal_gain,
  input wire logic [23:0] dma_addr,
  input wire logic [15:0] dma_data,
  input wire logic        dma_valid,
  input wire logic        dma_ready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_cfg_wr;
    sfr_wr && sfr_addr == ACC_CFG_ADDR;
  endsequence
  sequence s_hold_end;
    $fell(track_hold);
  endsequence
  property p_power;
    s_cfg_wr |=> converter_power_mode == $past(sfr_wdata[7]);
  endproperty
  property p_ref;
    s_cfg_wr |=> ext_ref_select == $past(sfr_wdata[6]);
  endproperty
  property p_rd_cfg;
    sfr_rd && !sfr_wr && sfr_addr == ACC_CFG_ADDR
      |=> sfr_rdata[7:6] == {converter_power_mode, ext_ref_select};
  endproperty
  property p_acq;
    $rose(track_hold) |-> track_hold [*4];
  endproperty
  property p_conv;
    s_hold_end |-> !sar_strobe [*8];
  endproperty
  property p_pulse;
    sar_strobe |=> !sar_strobe;
  endproperty
  property p_chan;
    track_hold |=> $stable(mux_channel);
  endproperty
  property p_cal;
    cal_wr |=> cal_offset == $past(cal_offset_in)
      && cal_gain == $past(cal_gain_in);
  endproperty
  property p_dma;
    dma_valid && !dma_ready
      |=> dma_valid && $stable(dma_data) && $stable(dma_addr);
  endproperty
  property p_factory;
    $rose(rst_b) |-> cal_gain == ACC_GAIN_FACTORY
      && cal_offset == ACC_OFS_FACTORY;
  endproperty
  a_power: assert property (p_power) else $error("power bit lost");
  a_ref: assert property (p_ref) else $error("ref select lost");
  a_rd_cfg: assert property (p_rd_cfg) else $error("cfg readback");
  a_acq: assert property (p_acq) else $error("acquire too short");
  a_conv: assert property (p_conv) else $error("convert too short");
  a_pulse: assert property (p_pulse) else $error("strobe too long");
  a_chan: assert property (p_chan) else $error("channel moved");
  a_cal: assert property (p_cal) else $error("cal not loaded");
  a_dma: assert property (p_dma) else $error("sample dropped");
  a_factory: assert property (p_factory) else $error("no factory");
endmodule : acc_checker
bind acc_conversion_control acc_checker u_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata), .cal_wr(cal_wr), .cal_offset_in(cal_offset_in),
  .cal_gain_in(cal_gain_in), .converter_power_mode(converter_power_mode),
  .ext_ref_select(ext_ref_select), .mux_channel(mux_channel),
  .track_hold(track_hold), .sar_strobe(sar_strobe),
  .cal_offset(cal_offset), .cal_gain(cal_gain), .dma_addr(dma_addr),
  .dma_data(dma_data), .dma_valid(dma_valid), .dma_ready(dma_ready)
);

/* File: verif/tb_top.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ns
module tb_top;
  import acc_pkg::*;
  logic        ref_clk, rst_b, sfr_wr, sfr_rd, tmr, cal_wr, pin_b;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, ofs_in, gain_in, ofs, gain;
  logic [11:0] sar_code;
  logic [3:0]  chan;
  logic [23:0] dma_addr;
  logic [15:0] dma_data;
  logic        pwr, xref, hold, strobe, dma_valid, dma_ready, pin_go, stall;
  logic [7:0]  v;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  acc_conversion_control uut (.ref_clk(ref_clk), .rst_b(rst_b),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .timer_overflow(tmr),
    .external_convert_pin_b(pin_b), .cal_wr(cal_wr),
    .cal_offset_in(ofs_in), .cal_gain_in(gain_in), .sar_code(sar_code),
    .converter_power_mode(pwr), .ext_ref_select(xref), .mux_channel(chan),
    .track_hold(hold), .sar_strobe(strobe), .cal_offset(ofs),
    .cal_gain(gain), .dma_addr(dma_addr), .dma_data(dma_data),
    .dma_valid(dma_valid), .dma_ready(dma_ready));
  acc_far_model far (.ref_clk(ref_clk), .mux_channel(chan), .pin_go(pin_go),
    .stall(stall), .sar_code(sar_code), .external_convert_pin_b(pin_b),
    .dma_ready(dma_ready));
  // clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    #400000;
    n_mismatch++;
    final_report();
  end
  task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(logic [7:0] a, logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
    @(negedge ref_clk);
  endtask : wr
  task automatic rd(logic [7:0] a);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    @(negedge ref_clk);
    v = sfr_rdata;
  endtask : rd
  // counts strobes seen over a span of cycles
  task automatic count(int span, output int c);
    c = 0;
    repeat (span) begin
      @(negedge ref_clk);
      if (strobe === 1'b1) c++;
    end
  endtask : count
  task automatic t_reset();
    rd(ACC_CFG_ADDR);
    check("cfg reset", v, ACC_CFG_RESET);
    rd(ACC_CTL2_ADDR);
    check("ctl2 reset", v, ACC_CTL2_RESET);
    rd(8'h00);
    check("unmapped", v, 8'h00);
    check("factory gain", gain, ACC_GAIN_FACTORY);
  endtask : t_reset
  // software starts across divider and acquisition codes and channels
  task automatic t_single();
    logic [3:0] chs [4] = '{4'h0, 4'h3, 4'h7, ACC_TEMP_CH};
    int div [4] = '{8, 4, 16, 32};
    int n, e;
    for (int i = 0; i < 4; i++) begin
      wr(ACC_CFG_ADDR, 8'h80 | 8'(i << 4) | 8'(i << 2) | 8'(i << 6));
      check("ext ref", xref, 24'(i & 1));
      wr(ACC_CTL2_ADDR, {4'h1, chs[i]});
      n = 0;
      while (strobe !== 1'b1 && n < 2000) begin
        @(negedge ref_clk);
        n++;
      end
      e = div[i] * (i + 18);
      // strobe seen one negedge before acquire plus 17 converter clocks
      check("conv time", 24'(n), 24'(e - 1));
      @(negedge ref_clk);
      rd(ACC_RES_LO_ADDR);
      check("result lo", v, {4'h5, chs[i]});
      rd(ACC_RES_HI_ADDR);
      check("result hi", v, {chs[i], 4'ha});
      rd(ACC_CTL2_ADDR);
      check("done flag", v, {4'h8, chs[i]});
      wr(ACC_CTL2_ADDR, 8'h00);
    end
  endtask : t_single
  // timer and pin triggers, with retriggers during acquisition
  task automatic t_trig();
    int c;
    wr(ACC_CFG_ADDR, 8'hbb);
    tmr = 1'b1;
    @(negedge ref_clk);
    tmr = 1'b0;
    repeat (3) @(negedge ref_clk);
    tmr = 1'b1;
    pin_go = 1'b1;
    @(negedge ref_clk);
    tmr = 1'b0;
    pin_go = 1'b0;
    count(1000, c);
    check("retrigger", 24'(c), 1);
    pin_go = 1'b1;
    @(negedge ref_clk);
    pin_go = 1'b0;
    count(1000, c);
    check("pin start", 24'(c), 1);
    wr(ACC_CFG_ADDR, 8'hb8);
    tmr = 1'b1;
    @(negedge ref_clk);
    tmr = 1'b0;
    count(1000, c);
    check("timer off", 24'(c), 0);
    wr(ACC_CTL2_ADDR, 8'h25);
    count(1500, c);
    check("continuous", 24'(c), 2);
    wr(ACC_CTL2_ADDR, 8'h00);
    count(1000, c);
  endtask : t_trig
  // stream capture with the sink stalling until the buffer is full
  task automatic t_dma();
    stall = 1'b1;
    wr(ACC_CTL2_ADDR, 8'h40);
    repeat (3000) @(negedge ref_clk);
    // drain while dma stays on: the address restarts when dma ends
    stall = 1'b0;
    for (int k = 0; k < 4; k++) begin
      for (int w = 0; w < 100 && dma_valid !== 1'b1; w++) @(negedge ref_clk);
      check("dma data", dma_data, {4'(k), 8'ha5, 4'(k)});
      check("dma addr", dma_addr, 24'(2 * k));
      @(negedge ref_clk);
    end
    wr(ACC_CTL2_ADDR, 8'h00);
  endtask : t_dma
  task automatic t_cal();
    ofs_in = 8'h3c;
    gain_in = 8'hc3;
    cal_wr = 1'b1;
    @(negedge ref_clk);
    cal_wr = 1'b0;
    rd(ACC_OFS_ADDR);
    check("offset", v, 8'h3c);
    check("gain", gain, 8'hc3);
  endtask : t_cal
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  // reset then the scenarios in turn
  initial begin
    {rst_b, sfr_wr, sfr_rd, tmr, cal_wr, pin_go, stall} = '0;
    {sfr_addr, sfr_wdata, ofs_in, gain_in} = '0;
    repeat (5) @(negedge ref_clk);
    rst_b = 1'b1;
    @(negedge ref_clk);
    t_reset();
    t_single();
    t_trig();
    t_dma();
    t_cal();
    final_report();
  end
endmodule : tb_top
